// ==== design/usfc_pkg.sv ====
// frame format and operating mode constants and types
`default_nettype none
package usfc_pkg;
    // register map, printed offsets
    localparam logic [15:0] FRAME_FORMAT_OFS  = 16'hfd28;
    localparam logic [15:0] OP_MODE_OFS       = 16'hfd2a;
    localparam logic [7:0]  FRAME_FORMAT_RST  = 8'h00;
    localparam logic [7:0]  OP_MODE_RST       = 8'h00;
    // writable bits; the rest is reserved and reads zero
    localparam logic [7:0]  FRAME_FORMAT_WMASK = 8'h7f;
    localparam logic [7:0]  OP_MODE_WMASK      = 8'h3f;
    localparam logic [7:0]  RDATA_IDLE         = 8'h00;

    // data width codes
    localparam logic [1:0] WIDTH_EIGHT = 2'h0;
    localparam logic [1:0] WIDTH_SEVEN = 2'h1;
    localparam logic [1:0] WIDTH_NINE  = 2'h2;
    localparam logic [1:0] WIDTH_LOOP  = 2'h3;
    localparam logic [3:0] DBITS_SEVEN = 4'h7;
    localparam logic [3:0] DBITS_EIGHT = 4'h8;
    localparam logic [3:0] DBITS_NINE  = 4'h9;

    // parity select codes
    localparam logic [1:0] PAR_ODD   = 2'h0;
    localparam logic [1:0] PAR_EVEN  = 2'h1;
    localparam logic [1:0] PAR_MARK  = 2'h2;
    localparam logic [1:0] PAR_SPACE = 2'h3;

    // core clock periods per bit
    localparam logic [4:0] ASYNC_OVERSAMPLE = 5'h10;
    localparam logic [4:0] SYNC_OVERSAMPLE  = 5'h01;

    typedef struct packed {
        logic       rsvd;
        logic       parity_on;
        logic [1:0] parity_sel;
        logic       tx_ninth_bit;
        logic       stop_count_sel;
        logic [1:0] width_sel;
    } usfc_frame_type;

    typedef struct packed {
        logic [1:0] rsvd;
        logic       rx_dma_request_on;
        logic       tx_dma_request_on;
        logic       sync_clock_source;
        logic       force_line_break;
        logic       attention_enable;
        logic       sync_select;
    } usfc_mode_type;

    // decoded settings handed to the shifters and baud logic
    typedef struct packed {
        logic [3:0] data_bits;
        logic       loopback;
        logic       two_stop;
        logic       tx_ninth;
        logic       parity_active;
        logic [1:0] parity_sel;
        logic       sync_mode;
        logic       attention;
        logic       ext_clock;
        logic [4:0] clk_ratio;
    } usfc_cfg_type;

    // decode of both registers at their reset value, so that the first
    // edge after reset shows no meaningless zero width or ratio
    localparam usfc_cfg_type CFG_RST = '{
        data_bits: DBITS_EIGHT, clk_ratio: ASYNC_OVERSAMPLE, default: '0};
endpackage
`default_nettype wire

// ==== design/usfc_ctrl.sv ====
// frame format and operating mode registers with their decode
`default_nettype none
module usfc_ctrl
    import usfc_pkg::*;
#(
    parameter int ADDR_W = 16
) (
    // clock and reset
    input  wire logic              core_clk_i,
    input  wire logic              resetn_i,
    // register port
    input  wire logic [ADDR_W-1:0] reg_addr_i,
    input  wire logic [7:0]        reg_wdata_i,
    input  wire logic              reg_wr_i,
    input  wire logic              reg_rd_i,
    output logic [7:0]             reg_rdata_o,
    // buffer flags and interrupt enables
    input  wire logic              tx_buffer_empty_flag_i,
    input  wire logic              rx_buffer_full_flag_i,
    input  wire logic              tx_irq_enable_i,
    input  wire logic              rx_irq_enable_i,
    // receiver and transmitter cores
    input  wire logic              rx_char_done_i,
    input  wire logic              rx_ninth_bit_i,
    input  wire logic              tx_shift_line_i,
    input  wire logic              baud_clk_i,
    // decoded settings and requests
    output var usfc_cfg_type       cfg_o,
    output logic                   tx_dma_req_o,
    output logic                   rx_dma_req_o,
    output logic                   tx_irq_o,
    output logic                   rx_irq_o,
    output logic                   ext_clk_rise_o,
    // serial pins
    output logic                   serial_tx_line_o,
    input  wire logic              serial_clock_pin_i,
    output logic                   serial_clock_pin_o,
    output logic                   serial_clock_pin_oe_n_o
);

    if (ADDR_W < 16) begin : g_addr_chk
        $error("usfc_ctrl: ADDR_W must hold a 16-bit offset");
    end

    usfc_frame_type frame_reg;
    usfc_mode_type  mode_reg;
    usfc_cfg_type   cfg_next;
    logic           sclk_meta_reg;
    logic           sclk_sync_reg;
    logic           sclk_prev_reg;
    logic           nine_bit;
    logic           frame_hit;
    logic           mode_hit;
    logic           atn_clear;

    function automatic logic addr_is(input logic [ADDR_W-1:0] a,
                                     input logic [15:0] ofs);
        return a == ADDR_W'(ofs);
    endfunction

    function automatic logic is_nine(input logic [1:0] w);
        return (w == WIDTH_NINE) || (w == WIDTH_LOOP);
    endfunction

    function automatic logic [3:0] width_bits(input logic [1:0] w);
        logic [3:0] b;
        b = DBITS_EIGHT;
        if (w == WIDTH_SEVEN) begin
            b = DBITS_SEVEN;
        end else if (is_nine(w)) begin
            b = DBITS_NINE;
        end
        return b;
    endfunction

    assign frame_hit = addr_is(reg_addr_i, FRAME_FORMAT_OFS);
    assign mode_hit  = addr_is(reg_addr_i, OP_MODE_OFS);
    assign nine_bit  = is_nine(frame_reg.width_sel);

    // address frame: nine-bit character with ninth bit set
    assign atn_clear = rx_char_done_i && rx_ninth_bit_i && nine_bit;

    // frame format register
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            frame_reg <= FRAME_FORMAT_RST;
        end else if (reg_wr_i && frame_hit) begin
            frame_reg <= reg_wdata_i & FRAME_FORMAT_WMASK;
        end
    end

    // mode register; a software write in the same cycle as an address
    // frame wins, since it carries the newer intent
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mode_reg <= OP_MODE_RST;
        end else if (reg_wr_i && mode_hit) begin
            mode_reg <= reg_wdata_i & OP_MODE_WMASK;
        end else if (atn_clear) begin
            mode_reg.attention_enable <= 1'b0;
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            reg_rdata_o <= RDATA_IDLE;
        end else if (reg_rd_i && frame_hit) begin
            reg_rdata_o <= frame_reg;
        end else if (reg_rd_i && mode_hit) begin
            reg_rdata_o <= mode_reg;
        end else begin
            reg_rdata_o <= RDATA_IDLE;
        end
    end

    // settings decode
    always_comb begin
        cfg_next.data_bits  = width_bits(frame_reg.width_sel);
        cfg_next.loopback   = frame_reg.width_sel == WIDTH_LOOP;
        cfg_next.two_stop   = frame_reg.stop_count_sel;
        cfg_next.tx_ninth   = nine_bit && frame_reg.tx_ninth_bit;
        cfg_next.parity_active = frame_reg.parity_on && !nine_bit
                              && !mode_reg.attention_enable;
        // select kept even when inactive; the shifter ignores it then
        cfg_next.parity_sel = frame_reg.parity_sel;
        cfg_next.sync_mode  = mode_reg.sync_select;
        cfg_next.attention  = mode_reg.attention_enable;
        cfg_next.ext_clock  = mode_reg.sync_select
                           && mode_reg.sync_clock_source;
        cfg_next.clk_ratio  = mode_reg.sync_select ? SYNC_OVERSAMPLE
                                                   : ASYNC_OVERSAMPLE;
    end

    // registered so the shifters see a clean, glitch-free word
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cfg_o <= CFG_RST;
        end else begin
            cfg_o <= cfg_next;
        end
    end

    // transmit line; break overrides whatever the shifter sends
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            serial_tx_line_o <= 1'b1;
        end else begin
            serial_tx_line_o <= tx_shift_line_i
                             && !mode_reg.force_line_break;
        end
    end

    // serial clock pin: driven only in synchronous internal-clock mode
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            serial_clock_pin_o      <= 1'b1;
            serial_clock_pin_oe_n_o <= 1'b1;
        end else begin
            serial_clock_pin_o      <= baud_clk_i;
            serial_clock_pin_oe_n_o <= !(mode_reg.sync_select
                                    && !mode_reg.sync_clock_source);
        end
    end

    // external clock synchroniser and rising edge detect
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sclk_meta_reg <= 1'b0;
            sclk_sync_reg <= 1'b0;
            sclk_prev_reg <= 1'b0;
        end else begin
            sclk_meta_reg <= serial_clock_pin_i;
            sclk_sync_reg <= sclk_meta_reg;
            sclk_prev_reg <= sclk_sync_reg;
        end
    end

    // edges only count when the external source is selected
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ext_clk_rise_o <= 1'b0;
        end else begin
            ext_clk_rise_o <= sclk_sync_reg && !sclk_prev_reg
                           && mode_reg.sync_select
                           && mode_reg.sync_clock_source;
        end
    end

    // requests follow the flags without delay
    assign tx_dma_req_o = tx_buffer_empty_flag_i
                       && mode_reg.tx_dma_request_on;
    assign rx_dma_req_o = rx_buffer_full_flag_i
                       && mode_reg.rx_dma_request_on;
    assign tx_irq_o = tx_buffer_empty_flag_i && tx_irq_enable_i
                   && !mode_reg.tx_dma_request_on;
    assign rx_irq_o = rx_buffer_full_flag_i && rx_irq_enable_i
                   && !mode_reg.rx_dma_request_on;

    a_width_seven: assert property (
        @(posedge core_clk_i) disable iff (!resetn_i)
        frame_reg.width_sel == WIDTH_SEVEN |=>
            cfg_o.data_bits == DBITS_SEVEN && !cfg_o.loopback)
        else $error("seven-bit code not decoded");

    a_width_eight: assert property (
        @(posedge core_clk_i) disable iff (!resetn_i)
        frame_reg.width_sel == WIDTH_EIGHT && frame_reg.parity_on
            && !mode_reg.attention_enable |=>
            cfg_o.data_bits == DBITS_EIGHT && cfg_o.parity_active)
        else $error("parity changed data width");

    a_loop_nine: assert property (
        @(posedge core_clk_i) disable iff (!resetn_i)
        frame_reg.width_sel == WIDTH_LOOP |=>
            cfg_o.loopback && cfg_o.data_bits == DBITS_NINE)
        else $error("loopback code not decoded");

    a_stop_count: assert property (
        @(posedge core_clk_i) disable iff (!resetn_i)
        1'b1 |=> cfg_o.two_stop == $past(frame_reg.stop_count_sel))
        else $error("stop count not following register");

    a_ninth_gate: assert property (
        @(posedge core_clk_i) disable iff (!resetn_i)
        !nine_bit |=> !cfg_o.tx_ninth)
        else $error("ninth bit leaked into short frame");

    a_ninth_value: assert property (
        @(posedge core_clk_i) disable iff (!resetn_i)
        frame_reg.width_sel == WIDTH_NINE && frame_reg.tx_ninth_bit
            |=> cfg_o.tx_ninth)
        else $error("ninth bit value lost");

    a_nine_no_par: assert property (
        @(posedge core_clk_i) disable iff (!resetn_i)
        nine_bit |=> !cfg_o.parity_active)
        else $error("parity active in nine-bit frame");

    a_atn_no_par: assert property (
        @(posedge core_clk_i) disable iff (!resetn_i)
        mode_reg.attention_enable |=> !cfg_o.parity_active)
        else $error("parity active in attention mode");

    a_par_off: assert property (
        @(posedge core_clk_i) disable iff (!resetn_i)
        !frame_reg.parity_on |=> !cfg_o.parity_active)
        else $error("parity active while disabled");

    a_frame_rdback: assert property (
        @(posedge core_clk_i) disable iff (!resetn_i)
        reg_wr_i && frame_hit ##1 reg_rd_i && frame_hit |=>
            reg_rdata_o == ($past(reg_wdata_i, 2) & FRAME_FORMAT_WMASK))
        else $error("frame format read-back mismatch");

    a_rsvd_zero: assert property (
        @(posedge core_clk_i) disable iff (!resetn_i)
        $past(reg_rd_i && mode_hit) |-> reg_rdata_o[7:6] == 2'h0)
        else $error("reserved mode bits read nonzero");

    a_atn_clear: assert property (
        @(posedge core_clk_i) disable iff (!resetn_i)
        atn_clear && !(reg_wr_i && mode_hit) |=>
            !mode_reg.attention_enable ##1 !cfg_o.attention)
        else $error("address frame did not clear attention");

    a_brk_low: assert property (
        @(posedge core_clk_i) disable iff (!resetn_i)
        mode_reg.force_line_break [*2] |-> !serial_tx_line_o)
        else $error("transmit line not held low in break");

    a_sclk_drive: assert property (
        @(posedge core_clk_i) disable iff (!resetn_i)
        mode_reg.sync_select && !mode_reg.sync_clock_source |=>
            !serial_clock_pin_oe_n_o
            && serial_clock_pin_o == $past(baud_clk_i))
        else $error("serial clock not driven");

    a_async_float: assert property (
        @(posedge core_clk_i) disable iff (!resetn_i)
        !mode_reg.sync_select |=> serial_clock_pin_oe_n_o
            && !ext_clk_rise_o && cfg_o.clk_ratio == ASYNC_OVERSAMPLE)
        else $error("clock pin active in asynchronous mode");

    a_dma_tx: assert property (
        @(posedge core_clk_i) disable iff (!resetn_i)
        tx_dma_req_o |-> tx_buffer_empty_flag_i && !tx_irq_o)
        else $error("transmit request without empty flag");

    a_dma_rx: assert property (
        @(posedge core_clk_i) disable iff (!resetn_i)
        rx_buffer_full_flag_i && mode_reg.rx_dma_request_on
            |-> rx_dma_req_o && !rx_irq_o)
        else $error("receive request missing or irq not suppressed");

    a_frame_rsvd: assert property (
        @(posedge core_clk_i) disable iff (!resetn_i)
        $past(reg_rd_i && frame_hit) |-> !reg_rdata_o[7])
        else $error("reserved frame bit reads nonzero");

    a_psel_pass: assert property (
        @(posedge core_clk_i) disable iff (!resetn_i)
        1'b1 |=> cfg_o.parity_sel == $past(frame_reg.parity_sel))
        else $error("parity select not following register");

    a_sync_follow: assert property (
        @(posedge core_clk_i) disable iff (!resetn_i)
        1'b1 |=> cfg_o.sync_mode == $past(mode_reg.sync_select))
        else $error("sync mode not following register");

    a_attn_follow: assert property (
        @(posedge core_clk_i) disable iff (!resetn_i)
        1'b1 |=> cfg_o.attention == $past(mode_reg.attention_enable))
        else $error("attention not following register");

    a_sync_ratio: assert property (
        @(posedge core_clk_i) disable iff (!resetn_i)
        mode_reg.sync_select |=> cfg_o.clk_ratio == SYNC_OVERSAMPLE)
        else $error("synchronous clock ratio wrong");

    a_tx_follow: assert property (
        @(posedge core_clk_i) disable iff (!resetn_i)
        !mode_reg.force_line_break |=>
            serial_tx_line_o == $past(tx_shift_line_i))
        else $error("transmit line not following shifter");

    a_irq_gate: assert property (
        @(posedge core_clk_i) disable iff (!resetn_i)
        tx_irq_o || rx_irq_o |-> !(tx_irq_o && mode_reg.tx_dma_request_on)
            && !(rx_irq_o && mode_reg.rx_dma_request_on))
        else $error("interrupt raised while its DMA is enabled");

endmodule // usfc_ctrl
`default_nettype wire

// ==== testbench/usfc_remote.sv ====
// remote serial device: external clock source on the shared clock pin
`default_nettype none
module usfc_remote (
    // control from the bench
    input  wire logic ext_i,
    input  wire logic burst_i,
    // clock pin drive, low enable while driving
    output var logic  clk_o,
    output logic      clk_oe_n_o,
    output var int    edges_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // clock stands high between bursts so no stray edges appear
    initial begin
        clk_o = 1'b1;
        edges_o = 0;
        forever begin
            #62.5;
            if (burst_i || !clk_o) begin
                clk_o = ~clk_o;
                if (clk_o) edges_o++;
            end
        end
    end
    assign clk_oe_n_o = !ext_i;
endmodule // usfc_remote
`default_nettype wire

// ==== testbench/testbench.sv ====
// self-checking bench for the frame format and mode registers
`default_nettype none
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin \
    fails++; $display("Error %s expected %0h seen %0h", nm, ex, got); end end
module testbench;
    import usfc_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk_i = 1'b0, resetn_i = 1'b0;
    logic [15:0] addr = '0;
    logic [7:0] wdata = '0, rdata, d;
    logic wr = 0, rd = 0, empty = 0, full = 0, tie = 0, rie = 0;
    logic done = 0, ninth = 0, shift = 1, baud = 0, p_ext = 0, burst = 0;
    logic tx_dma, rx_dma, tx_irq, rx_irq, rise, txl, pin_o, oe_n, pin;
    logic p_clk, p_oe_n, float_q = 1'b0;
    usfc_cfg_type cfg;
    int fails = 0, compares = 0, p_edges;
    // undriven pin shows the inverse of its last level, never a stale value
    assign pin = !oe_n ? pin_o : (!p_oe_n ? p_clk : float_q);
    always @(posedge core_clk_i) float_q <= ~pin;
    usfc_ctrl u_usfc_ctrl (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_rdata_o(rdata), .tx_buffer_empty_flag_i(empty),
        .rx_buffer_full_flag_i(full), .tx_irq_enable_i(tie),
        .rx_irq_enable_i(rie), .rx_char_done_i(done), .rx_ninth_bit_i(ninth),
        .tx_shift_line_i(shift), .baud_clk_i(baud), .cfg_o(cfg),
        .tx_dma_req_o(tx_dma), .rx_dma_req_o(rx_dma), .tx_irq_o(tx_irq),
        .rx_irq_o(rx_irq), .ext_clk_rise_o(rise), .serial_tx_line_o(txl),
        .serial_clock_pin_i(pin), .serial_clock_pin_o(pin_o),
        .serial_clock_pin_oe_n_o(oe_n));
    usfc_remote u_usfc_remote (.ext_i(p_ext), .burst_i(burst),
        .clk_o(p_clk), .clk_oe_n_o(p_oe_n), .edges_o(p_edges));
    initial forever #5 core_clk_i = ~core_clk_i;
    task automatic wreg(input logic [15:0] a, input logic [7:0] v);
        @(posedge core_clk_i);
        wr <= 1'b1; addr <= a; wdata <= v;
        @(posedge core_clk_i);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [15:0] a, output logic [7:0] v);
        @(posedge core_clk_i);
        rd <= 1'b1; addr <= a;
        @(posedge core_clk_i);
        rd <= 1'b0;
        #1 v = rdata;
    endtask
    // cfg follows the registers one edge late
    task automatic settle();
        repeat (2) @(posedge core_clk_i);
        #1;
    endtask
    task automatic reg_map();
        rreg(FRAME_FORMAT_OFS, d); `CHK("frame reset", 8'h00, d)
        rreg(OP_MODE_OFS, d); `CHK("mode reset", 8'h00, d)
        `CHK("reset ratio", 5'h10, cfg.clk_ratio)
        wreg(FRAME_FORMAT_OFS, 8'hff);
        rreg(FRAME_FORMAT_OFS, d); `CHK("frame rsvd", 8'h7f, d)
        wreg(OP_MODE_OFS, 8'hff);
        rreg(OP_MODE_OFS, d); `CHK("mode rsvd", 8'h3f, d)
        wreg(OP_MODE_OFS, 8'h00);
        wreg(16'hfd2c, 8'h55);
        rreg(16'hfd2c, d); `CHK("unmapped", 8'h00, d)
        @(posedge core_clk_i); #1 `CHK("rdata idle", 8'h00, rdata)
        rreg(FRAME_FORMAT_OFS, d); `CHK("frame kept", 8'h7f, d)
        // write then read with no gap must return the new value
        @(posedge core_clk_i);
        wr <= 1'b1; addr <= FRAME_FORMAT_OFS; wdata <= 8'h35;
        @(posedge core_clk_i);
        wr <= 1'b0; rd <= 1'b1;
        @(posedge core_clk_i);
        rd <= 1'b0;
        #1 `CHK("b2b read", 8'h35, rdata)
    endtask
    task automatic widths();
        logic [1:0] c;
        for (int i = 0; i < 4; i++) begin
            c = i[1:0];
            wreg(FRAME_FORMAT_OFS, {2'b01, c, c[0], !c[0], c});
            settle();
            `CHK("bits", c == 2'h1 ? 4'h7 : (c == 2'h0 ? 4'h8 : 4'h9),
                 cfg.data_bits)
            `CHK("loopback", c == 2'h3, cfg.loopback)
            `CHK("ninth", c[1] & c[0], cfg.tx_ninth)
            `CHK("parity", !c[1], cfg.parity_active)
            `CHK("psel", c, cfg.parity_sel)
            `CHK("stops", !c[0], cfg.two_stop)
        end
        wreg(FRAME_FORMAT_OFS, 8'h00);
        settle(); `CHK("parity off", 1'b0, cfg.parity_active)
    endtask
    task automatic modes();
        logic [7:0] m [4] = '{8'h00, 8'h01, 8'h09, 8'h08};
        for (int i = 0; i < 4; i++) begin
            wreg(OP_MODE_OFS, m[i]);
            settle();
            `CHK("sync", m[i][0], cfg.sync_mode)
            `CHK("ratio", m[i][0] ? 5'h01 : 5'h10, cfg.clk_ratio)
            `CHK("ext", m[i][0] & m[i][3], cfg.ext_clock)
            `CHK("oe_n", !(m[i][0] & !m[i][3]), oe_n)
        end
        wreg(OP_MODE_OFS, 8'h01);
        baud <= 1'b1; settle(); `CHK("clk out hi", 1'b1, pin_o)
        baud <= 1'b0; settle(); `CHK("clk out lo", 1'b0, pin_o)
    endtask
    task automatic ext_burst(input logic [7:0] m, input logic en);
        int n, e0;
        p_ext <= 1'b1;
        wreg(OP_MODE_OFS, m);
        repeat (10) @(posedge core_clk_i);
        n = 0; e0 = p_edges; burst <= 1'b1;
        for (int k = 0; k < 100; k++) begin
            @(posedge core_clk_i);
            if (k == 50) burst <= 1'b0;
            #1;
            if (rise === 1'b1) n++;
        end
        `CHK("ext edges", en ? p_edges - e0 : 0, n)
        if (en) `CHK("ext some", 1'b1, n > 0)
        wreg(OP_MODE_OFS, 8'h00);
        p_ext <= 1'b0;
    endtask
    task automatic pulse(input logic n);
        @(posedge core_clk_i);
        done <= 1'b1; ninth <= n;
        @(posedge core_clk_i);
        done <= 1'b0;
    endtask
    task automatic attention();
        wreg(FRAME_FORMAT_OFS, 8'h40);
        wreg(OP_MODE_OFS, 8'h02);
        settle(); `CHK("attn", 1'b1, cfg.attention)
        `CHK("attn parity", 1'b0, cfg.parity_active)
        pulse(1'b1);
        rreg(OP_MODE_OFS, d); `CHK("attn 8bit", 8'h02, d)
        wreg(FRAME_FORMAT_OFS, 8'h02);
        pulse(1'b0);
        rreg(OP_MODE_OFS, d); `CHK("attn data", 8'h02, d)
        pulse(1'b1);
        rreg(OP_MODE_OFS, d); `CHK("attn clear", 8'h00, d)
    endtask
    task automatic line_break();
        wreg(OP_MODE_OFS, 8'h04);
        repeat (6) begin
            settle(); `CHK("break", 1'b0, txl)
        end
        wreg(OP_MODE_OFS, 8'h00);
        settle(); `CHK("break end", 1'b1, txl)
        @(posedge core_clk_i);
        shift <= 1'b0;
        settle(); `CHK("tx follows", 1'b0, txl)
        @(posedge core_clk_i);
        shift <= 1'b1;
        settle(); `CHK("tx idle", 1'b1, txl)
    endtask
    task automatic dma();
        logic [3:0] v;
        tie <= 1'b1; rie <= 1'b1;
        for (int i = 0; i < 16; i++) begin
            v = i[3:0];
            wreg(OP_MODE_OFS, {2'b00, v[3:2], 4'h0});
            empty <= v[0]; full <= v[1];
            settle();
            `CHK("tx dma", v[0] & v[2], tx_dma)
            `CHK("rx dma", v[1] & v[3], rx_dma)
            `CHK("tx irq", v[0] & !v[2], tx_irq)
            `CHK("rx irq", v[1] & !v[3], rx_irq)
        end
        wreg(OP_MODE_OFS, 8'h00);
        tie <= 1'b0; rie <= 1'b0; empty <= 1'b1; full <= 1'b1;
        settle();
        `CHK("tx irq off", 1'b0, tx_irq)
        `CHK("rx irq off", 1'b0, rx_irq)
    endtask
    task automatic results();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge core_clk_i);
        resetn_i <= 1'b1;
        reg_map();
        widths();
        modes();
        ext_burst(8'h09, 1'b1);
        ext_burst(8'h08, 1'b0);
        attention();
        line_break();
        dma();
        results();
    end
    // cuts a hang short
    initial begin
        #200us;
        fails++;
        results();
    end
endmodule // testbench
`default_nettype wire
